// ===== common/rst_ctrl_pkg.sv
// Package for the reset source and start-up controller.
// Assumes a single crystal-rate clock; all slower rates are enables.
package rst_ctrl_pkg;

    // Clock and divider figures
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned CLKS_PER_ALE   = 6;   // Strobe at one sixth of crystal
    localparam int unsigned ALES_PER_MC    = 2;   // Two strobes per machine cycle
    localparam int unsigned ALE_HIGH_CLKS  = 2;   // Strobe high phase width
    localparam int unsigned PHASE_W        = 3;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h5;
    localparam logic [PHASE_W-1:0] ALE_HIGH   = 3'h2;

    // Watchdog timeout in machine cycles
    localparam int unsigned WDT_TIMEOUT_MC = 122_800;
    localparam int unsigned WDT_CNT_W      = 17;
    localparam logic        WDT_EN_RST     = 1'b1; // Running at power-on

    // Reset stretch after the last source goes away, machine cycles
    localparam int unsigned RST_HOLD_MC    = 4;
    localparam int unsigned HOLD_W         = 4;

    // Timed-access unlock sequence
    localparam logic [7:0] TA_KEY1        = 8'hAA;
    localparam logic [7:0] TA_KEY2        = 8'h55;
    localparam int unsigned TA_WINDOW_MC  = 3;
    localparam int unsigned TA_WINDOW_CLKS = TA_WINDOW_MC * CLKS_PER_ALE * ALES_PER_MC;
    localparam int unsigned TA_CNT_W      = 6;

    // Power control register layout
    localparam int unsigned PCR_STOP_BIT  = 1;
    localparam int unsigned PCR_WDF_BIT   = 4;
    localparam int unsigned PCR_PINF_BIT  = 6;
    localparam logic [7:0]  PCR_PLAIN_MASK = 8'hAD; // Bits 7,5,3,2,0 store directly
    localparam logic [7:0]  PCR_RST        = 8'h00;

    // Integrity check
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_CHECK,
        ST_LOADER,
        ST_RUN
    } boot_state_e;

endpackage

// ===== hw/prog_store.sv
// Program store scanned by the start-up integrity check.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module prog_store #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [7:0]        rd_data_o
);

    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // Write port used by the loader
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read; contents need no reset, they model retained storage
    always_ff @(posedge ref_clk_i)
    begin
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// ===== hw/rst_ctrl.sv
// Reset sources, cause flags, stop-bit protection, fetch select and
// power-up integrity check of a small microcontroller core.
// Assumes all inputs except the async reset rstn_i are synchronous to ref_clk_i (the crystal clock).
`timescale 1ns/1ps

module rst_ctrl
    import rst_ctrl_pkg::*;
#(
    parameter int unsigned WDT_TIMEOUT = WDT_TIMEOUT_MC,
    parameter int unsigned ADDR_W      = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              ext_reset_i,
    input  wire logic              supply_fail_threshold_i,
    input  wire logic              wdt_restart_i,
    input  wire logic              wdt_ctrl_wr_i,
    input  wire logic              wdt_ctrl_en_i,
    input  wire logic              ta_wr_i,
    input  wire logic [7:0]        ta_wdata_i,
    input  wire logic              pcr_wr_i,
    input  wire logic [7:0]        pcr_wdata_i,
    input  wire logic              external_access_input_n_i,
    input  wire logic              lock_i,
    input  wire logic              check_en_i,
    input  wire logic [15:0]       check_stored_i,
    input  wire logic              mem_wr_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    input  wire logic [7:0]        mem_wdata_i,
    output logic                   cpu_reset_o,
    output logic                   ale_o,
    output logic                   mc_tick_o,
    output logic [7:0]             power_control_register_o,
    output logic                   stop_mode_o,
    output logic                   wdt_running_o,
    output logic                   ta_open_o,
    output logic                   ext_bus_fetch_o,
    output logic                   int_nvram_en_o,
    output logic                   loader_mode_o,
    output logic                   app_run_o,
    output logic                   check_fail_o,
    output logic [15:0]            check_value_o
);

    // One CRC step over one byte, MSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {data, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    logic [PHASE_W-1:0]   phase_ff;
    logic                 half_ff;
    logic                 mc_en;
    logic                 ale_ff;
    logic [WDT_CNT_W-1:0] wdt_cnt_ff;
    logic                 wdt_en_ff;
    logic                 wdt_fire;
    logic                 pin_flag_ff;
    logic                 watchdog_cause_flag_ff;
    logic                 hold_src;
    logic [HOLD_W-1:0]    hold_cnt_ff;
    logic                 cpu_reset_ff;
    logic                 ta_armed_ff;
    logic [TA_CNT_W-1:0]  ta_cnt_ff;
    logic [7:0]           pcr_ff;
    logic                 power_up_ff;
    boot_state_e          state_ff;
    boot_state_e          nxt_state;
    logic [ADDR_W-1:0]    scan_addr_ff;
    logic                 scan_last_ff;
    logic                 rd_valid_ff;
    logic [15:0]          crc_ff;
    logic                 check_fail_ff;
    logic [7:0]           rd_data;
    logic                 scan_done;

    localparam logic [WDT_CNT_W-1:0] WDT_LAST = WDT_CNT_W'(WDT_TIMEOUT - 1);
    localparam logic [HOLD_W-1:0]    HOLD_LAST = HOLD_W'(RST_HOLD_MC);
    localparam logic [TA_CNT_W-1:0]  TA_LOAD   = TA_CNT_W'(TA_WINDOW_CLKS);

    // Crystal divider; the oscillator is stopped in stop mode
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            phase_ff <= '0;
            half_ff  <= 1'b0;
        end
        else if (!pcr_ff[PCR_STOP_BIT])
        begin
            if (phase_ff == PHASE_LAST)
            begin
                phase_ff <= '0;
                half_ff  <= ~half_ff;
            end
            else
            begin
                phase_ff <= phase_ff + 1'b1;
            end
        end
    end

    assign mc_en = !pcr_ff[PCR_STOP_BIT] && (phase_ff == PHASE_LAST) && half_ff;

    // Address strobe, one pulse per six crystal clocks while running
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ale_ff <= 1'b0;
        end
        else
        begin
            ale_ff <= !cpu_reset_ff && !pcr_ff[PCR_STOP_BIT]
                      && (phase_ff < ALE_HIGH);
        end
    end

    // Watchdog enable survives warm resets, so it is never assumed off
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wdt_en_ff <= WDT_EN_RST;
        end
        else if (supply_fail_threshold_i)
        begin
            wdt_en_ff <= WDT_EN_RST;
        end
        else if (wdt_ctrl_wr_i && ta_open_o)
        begin
            wdt_en_ff <= wdt_ctrl_en_i;
        end
    end

    // Watchdog counter in machine cycles
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wdt_cnt_ff <= '0;
        end
        else if (cpu_reset_ff || !wdt_en_ff || wdt_restart_i)
        begin
            wdt_cnt_ff <= '0;
        end
        else if (mc_en)
        begin
            wdt_cnt_ff <= (wdt_cnt_ff == WDT_LAST) ? '0 : wdt_cnt_ff + 1'b1;
        end
    end

    assign wdt_fire = wdt_en_ff && !cpu_reset_ff && !wdt_restart_i && mc_en
                      && (wdt_cnt_ff == WDT_LAST);

    // Reset cause flags; supply failure reads as a power-on reset
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pin_flag_ff            <= 1'b0;
            watchdog_cause_flag_ff <= 1'b0;
        end
        else if (supply_fail_threshold_i)
        begin
            pin_flag_ff            <= 1'b0;
            watchdog_cause_flag_ff <= 1'b0;
        end
        else if (ext_reset_i)
        begin
            pin_flag_ff            <= 1'b1;
            watchdog_cause_flag_ff <= 1'b0;
        end
        else if (wdt_fire)
        begin
            pin_flag_ff            <= 1'b0;
            watchdog_cause_flag_ff <= 1'b1;
        end
        // Otherwise hold for software to read
    end

    assign hold_src = supply_fail_threshold_i || ext_reset_i || wdt_fire;

    // Processor reset, stretched a few machine cycles past the last source
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hold_cnt_ff  <= HOLD_LAST;
            cpu_reset_ff <= 1'b1;
        end
        else if (hold_src)
        begin
            hold_cnt_ff  <= HOLD_LAST;
            cpu_reset_ff <= 1'b1;
        end
        else if (hold_cnt_ff != '0)
        begin
            if (mc_en || pcr_ff[PCR_STOP_BIT])
            begin
                hold_cnt_ff <= hold_cnt_ff - 1'b1;
            end
        end
        else
        begin
            cpu_reset_ff <= 1'b0;
        end
    end

    // Power-up marker: set by power-on or supply failure, used by boot
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            power_up_ff <= 1'b1;
        end
        else if (supply_fail_threshold_i)
        begin
            power_up_ff <= 1'b1;
        end
        else if (state_ff == ST_RESET && !cpu_reset_ff)
        begin
            power_up_ff <= 1'b0;
        end
    end

    // Timed access: key one then key two opens a short write window
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ta_armed_ff <= 1'b0;
            ta_cnt_ff   <= '0;
        end
        else if (cpu_reset_ff)
        begin
            ta_armed_ff <= 1'b0;
            ta_cnt_ff   <= '0;
        end
        else if (ta_wr_i)
        begin
            ta_armed_ff <= (ta_wdata_i == TA_KEY1);
            ta_cnt_ff   <= (ta_armed_ff && ta_wdata_i == TA_KEY2) ? TA_LOAD : '0;
        end
        else if ((pcr_wr_i || wdt_ctrl_wr_i) && ta_open_o)
        begin
            ta_cnt_ff <= '0; // One protected write per unlock
        end
        else if (ta_cnt_ff != '0)
        begin
            ta_cnt_ff <= ta_cnt_ff - 1'b1;
        end
    end

    assign ta_open_o = (ta_cnt_ff != '0);

    // Power control register; stop bit guarded, reset clears it
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pcr_ff <= PCR_RST;
        end
        else if (hold_src)
        begin
            pcr_ff <= PCR_RST; // Any reset wakes the part from stop
        end
        else if (pcr_wr_i)
        begin
            pcr_ff <= (pcr_ff & ~PCR_PLAIN_MASK) | (pcr_wdata_i & PCR_PLAIN_MASK);
            if (ta_open_o)
            begin
                pcr_ff[PCR_STOP_BIT] <= pcr_wdata_i[PCR_STOP_BIT];
            end
        end
    end

    // Boot sequencing state
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= ST_RESET;
        end
        else if (cpu_reset_ff)
        begin
            state_ff <= ST_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign scan_done = rd_valid_ff && scan_last_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET:
            begin
                // A warm reset after a failed check must not start the application
                nxt_state = (power_up_ff && check_en_i) ? ST_CHECK
                          : ((check_fail_ff && !power_up_ff) ? ST_LOADER : ST_RUN);
            end
            ST_CHECK:
            begin
                if (scan_done)
                begin
                    nxt_state = (crc_byte(crc_ff, rd_data) == check_stored_i)
                                ? ST_RUN : ST_LOADER;
                end
            end
            ST_LOADER:
            begin
                nxt_state = ST_LOADER;
            end
            default:
            begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // Scan address and read pipeline; the store answers one cycle later
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scan_addr_ff <= '0;
            scan_last_ff <= 1'b0;
            rd_valid_ff  <= 1'b0;
        end
        else if (state_ff != ST_CHECK || scan_done)
        begin
            scan_addr_ff <= '0;
            scan_last_ff <= 1'b0;
            rd_valid_ff  <= 1'b0;
        end
        else
        begin
            rd_valid_ff  <= 1'b1;
            scan_last_ff <= (scan_addr_ff == '1);
            scan_addr_ff <= scan_addr_ff + 1'b1;
        end
    end

    // Check value accumulation
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            crc_ff <= CRC_INIT;
        end
        else if (state_ff == ST_RESET)
        begin
            crc_ff <= CRC_INIT;
        end
        else if (state_ff == ST_CHECK && rd_valid_ff)
        begin
            crc_ff <= crc_byte(crc_ff, rd_data);
        end
    end

    // Failure marker for software in the loader
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            check_fail_ff <= 1'b0;
        end
        else if (state_ff == ST_CHECK && scan_done)
        begin
            check_fail_ff <= (nxt_state == ST_LOADER);
        end
    end

    // The loader may rewrite the store only while not checking it
    prog_store #(
        .ADDR_W    (ADDR_W)
    ) u_store (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (mem_wr_i && state_ff != ST_CHECK),
        .wr_addr_i (mem_addr_i),
        .wr_data_i (mem_wdata_i),
        .rd_addr_i (scan_addr_ff),
        .rd_data_o (rd_data)
    );

    // Outputs
    assign cpu_reset_o     = cpu_reset_ff;
    assign ale_o           = ale_ff;
    assign mc_tick_o       = mc_en;
    assign stop_mode_o     = pcr_ff[PCR_STOP_BIT];
    assign wdt_running_o   = wdt_en_ff;
    assign loader_mode_o   = (state_ff == ST_CHECK) || (state_ff == ST_LOADER);
    assign app_run_o       = (state_ff == ST_RUN);
    assign check_fail_o    = check_fail_ff;
    assign check_value_o   = crc_ff;

    // Fetch source; lock overrides the pin so it may be grounded
    assign ext_bus_fetch_o = !external_access_input_n_i && !lock_i;
    assign int_nvram_en_o  = !ext_bus_fetch_o;

    // Read view with cause flags in their bit positions
    always_comb
    begin
        power_control_register_o               = pcr_ff;
        power_control_register_o[PCR_PINF_BIT] = pin_flag_ff;
        power_control_register_o[PCR_WDF_BIT]  = watchdog_cause_flag_ff;
    end

endmodule

// ===== tb/rst_ctrl_properties.sv
// Concurrent checks on the reset controller's top ports.
// Assumes one clock domain and the async active-low power-on reset.
`timescale 1ns/1ps
module rst_ctrl_chk (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       ext_reset_i,
    input  wire logic       supply_fail_threshold_i,
    input  wire logic       pcr_wr_i,
    input  wire logic       external_access_input_n_i,
    input  wire logic       lock_i,
    input  wire logic       cpu_reset_o,
    input  wire logic       ale_o,
    input  wire logic [7:0] power_control_register_o,
    input  wire logic       stop_mode_o,
    input  wire logic       wdt_running_o,
    input  wire logic       ta_open_o,
    input  wire logic       ext_bus_fetch_o,
    input  wire logic       int_nvram_en_o,
    input  wire logic       loader_mode_o,
    input  wire logic       app_run_o,
    input  wire logic       check_fail_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // Cause flags as a pair, pin flag high
    wire logic [1:0] flags = {power_control_register_o[6], power_control_register_o[4]};

    supply_reset_a: assert property (supply_fail_threshold_i |=> cpu_reset_o && flags == 2'h0)
        else $error("supply fail gave no power-up style reset");
    pin_reset_a: assert property (ext_reset_i && !supply_fail_threshold_i |=> cpu_reset_o && flags == 2'h2)
        else $error("pin reset gave wrong reset or flags");
    flags_hold_a: assert property (!cpu_reset_o && !$past(cpu_reset_o) |-> $stable(flags))
        else $error("cause flags moved outside a reset");
    wdt_flag_a: assert property ($rose(power_control_register_o[4]) |-> cpu_reset_o && $past(wdt_running_o))
        else $error("watchdog flag set without running watchdog");
    stop_guard_a: assert property (pcr_wr_i && !ta_open_o && !cpu_reset_o |=> $stable(stop_mode_o))
        else $error("stop bit changed by unprotected write");
    bus_select_a: assert property (ext_bus_fetch_o == (!external_access_input_n_i && !lock_i) && int_nvram_en_o == !ext_bus_fetch_o)
        else $error("fetch select wrong for access pin");
    lock_ignore_a: assert property (lock_i |-> !ext_bus_fetch_o && int_nvram_en_o)
        else $error("locked device left internal memory");
    // A warm reset holds the reset state through the reset and for one cycle after release before the loader again
    loader_hold_a: assert property (check_fail_o && !supply_fail_threshold_i |=> check_fail_o && !app_run_o && (loader_mode_o || cpu_reset_o || $past(cpu_reset_o)))
        else $error("application started after failed check");
    // Stop and reset legally cut the strobe short, so they end the low run
    ale_period_a: assert property ($fell(ale_o) |-> !ale_o [*4] ##1 (ale_o || cpu_reset_o || stop_mode_o))
        else $error("strobe period is not six clocks");

    cover property ($rose(power_control_register_o[4]));
    cover property ($rose(stop_mode_o));
    cover property ($rose(check_fail_o));
endmodule

bind rst_ctrl rst_ctrl_chk rst_ctrl_chk_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ext_reset_i(ext_reset_i),
    .supply_fail_threshold_i(supply_fail_threshold_i), .pcr_wr_i(pcr_wr_i),
    .external_access_input_n_i(external_access_input_n_i), .lock_i(lock_i),
    .cpu_reset_o(cpu_reset_o), .ale_o(ale_o), .power_control_register_o(power_control_register_o),
    .stop_mode_o(stop_mode_o), .wdt_running_o(wdt_running_o), .ta_open_o(ta_open_o),
    .ext_bus_fetch_o(ext_bus_fetch_o), .int_nvram_en_o(int_nvram_en_o),
    .loader_mode_o(loader_mode_o), .app_run_o(app_run_o), .check_fail_o(check_fail_o));

// ===== tb/testbench.sv
// Self-checking bench for the reset source and start-up controller.
// Assumes rst_ctrl with a shortened watchdog and a 16-byte program store.
`timescale 1ns/1ps
module testbench
    import rst_ctrl_pkg::*;
;
    localparam int unsigned WDT = 20;
    localparam int unsigned AW  = 4;

    logic          ref_clk_i = 1'b0;
    logic          rstn_i, ext_reset_i, supply_fail_threshold_i, wdt_restart_i, wdt_ctrl_wr_i;
    logic          wdt_ctrl_en_i, ta_wr_i, pcr_wr_i, external_access_input_n_i, lock_i;
    logic          check_en_i, mem_wr_i, prev_rst;
    logic [7:0]    ta_wdata_i, pcr_wdata_i, mem_wdata_i, d;
    logic [15:0]   check_stored_i, check_value_o, crc;
    logic [AW-1:0] mem_addr_i;
    logic          cpu_reset_o, ale_o, mc_tick_o, stop_mode_o, wdt_running_o, ta_open_o;
    logic          ext_bus_fetch_o, int_nvram_en_o, loader_mode_o, app_run_o, check_fail_o;
    logic [7:0]    power_control_register_o;
    logic [1:0]    exp_q[$];
    int            failures, checks_done, n, m, seed;

    rst_ctrl #(.WDT_TIMEOUT(WDT), .ADDR_W(AW)) rst_ctrl_i (
        .ref_clk_i, .rstn_i, .ext_reset_i, .supply_fail_threshold_i, .wdt_restart_i,
        .wdt_ctrl_wr_i, .wdt_ctrl_en_i, .ta_wr_i, .ta_wdata_i, .pcr_wr_i, .pcr_wdata_i,
        .external_access_input_n_i, .lock_i, .check_en_i, .check_stored_i, .mem_wr_i,
        .mem_addr_i, .mem_wdata_i, .cpu_reset_o, .ale_o, .mc_tick_o,
        .power_control_register_o, .stop_mode_o, .wdt_running_o, .ta_open_o,
        .ext_bus_fetch_o, .int_nvram_en_o, .loader_mode_o, .app_run_o, .check_fail_o,
        .check_value_o);

    // 40 MHz crystal clock
    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask

    // Bounded wait for the processor to leave reset
    task automatic wait_run();
        n = 0;
        while (cpu_reset_o !== 1'b0 && n < 400)
        begin
            step(1);
            n++;
        end
        chk(16'(cpu_reset_o), 16'h0, "reset release");
    endtask

    task automatic por();
        rstn_i = 1'b0;
        step(3);
        rstn_i = 1'b1;
        wait_run();
        chk(16'(power_control_register_o[6:4]), 16'h0, "power-up flags");
        chk(16'(wdt_running_o), 16'h1, "watchdog on at start");
    endtask

    // Key pair then one protected write, either power control or watchdog enable
    task automatic ta_write(input logic is_pcr, input logic [7:0] v);
        ta_wr_i = 1'b1;
        ta_wdata_i = TA_KEY1;
        step(1);
        ta_wdata_i = TA_KEY2;
        step(1);
        chk(16'(ta_open_o), 16'h1, "window opened");
        ta_wr_i = 1'b0;
        pcr_wr_i = is_pcr;
        wdt_ctrl_wr_i = !is_pcr;
        pcr_wdata_i = v;
        wdt_ctrl_en_i = v[0];
        step(1);
        chk(16'(ta_open_o), 16'h0, "window spent by write");
        pcr_wr_i = 1'b0;
        wdt_ctrl_wr_i = 1'b0;
        step(1);
    endtask

    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++)
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction

    // Each new warm reset is matched against the oldest expected cause
    always @(posedge ref_clk_i)
    begin
        #1;
        if (rstn_i === 1'b1 && cpu_reset_o === 1'b1 && prev_rst === 1'b0)
        begin
            chk(16'(exp_q.size() > 0), 16'h1, "reset not expected");
            if (exp_q.size() > 0)
                chk(16'({power_control_register_o[6], power_control_register_o[4]}),
                    16'(exp_q.pop_front()), "cause flags");
        end
        prev_rst = cpu_reset_o;
    end

    // Hang guard, well beyond the expected run length
    initial
    begin
        #(25 * 40000);
        failures++;
        $display("[FAIL] %0t run timed out", $time);
        give_verdict();
    end

    initial
    begin
        {rstn_i, ext_reset_i, supply_fail_threshold_i, wdt_restart_i, wdt_ctrl_wr_i} = '0;
        {wdt_ctrl_en_i, ta_wr_i, pcr_wr_i, lock_i, check_en_i, mem_wr_i, prev_rst} = '0;
        {ta_wdata_i, pcr_wdata_i, mem_wdata_i, check_stored_i, mem_addr_i} = '0;
        external_access_input_n_i = 1'b1;
        seed = 19713;
        por();
        // Unserviced watchdog: reset after the timeout, within one machine cycle
        exp_q.push_back(2'h1);
        n = 0;
        while (cpu_reset_o !== 1'b1 && n < WDT * 24)
        begin
            step(1);
            n++;
        end
        chk(16'(n >= (WDT - 1) * 12 && n <= WDT * 12 + 12), 16'h1, "watchdog period");
        wait_run();
        // Serviced watchdog stays quiet, then is switched off under timed access
        n = 0;
        repeat (WDT * 5)
        begin
            wdt_restart_i = 1'b1;
            step(1);
            wdt_restart_i = 1'b0;
            repeat (WDT * 6)
            begin
                step(1);
                n += int'(cpu_reset_o !== 1'b0);
            end
        end
        chk(16'(n), 16'h0, "reset while serviced");
        ta_write(1'b0, 8'h00);
        chk(16'(wdt_running_o), 16'h0, "watchdog off");
        step(WDT * 30);
        chk(16'(cpu_reset_o), 16'h0, "reset while off");
        // Machine-cycle ticks and strobe duty over a whole number of periods
        n = 0;
        m = 0;
        repeat (120)
        begin
            step(1);
            n += int'(mc_tick_o === 1'b1);
            m += int'(ale_o === 1'b1);
        end
        chk(16'(n), 16'(120 / (CLKS_PER_ALE * ALES_PER_MC)), "machine ticks");
        chk(16'(m), 16'(120 / CLKS_PER_ALE * ALE_HIGH_CLKS), "strobe high clocks");
        // Pin reset, flags held after release
        exp_q.push_back(2'h2);
        ext_reset_i = 1'b1;
        step(2);
        ext_reset_i = 1'b0;
        wait_run();
        step(30);
        chk(16'({power_control_register_o[6], power_control_register_o[4]}), 16'h2, "held");
        // Supply fail behaves as power-up and rearms the watchdog
        exp_q.push_back(2'h0);
        supply_fail_threshold_i = 1'b1;
        step(2);
        supply_fail_threshold_i = 1'b0;
        wait_run();
        chk(16'(wdt_running_o), 16'h1, "watchdog rearmed");
        ta_write(1'b0, 8'h00);
        // Plain writes store, the stop bit refuses them
        repeat (6)
        begin
            d = 8'($random(seed));
            pcr_wr_i = 1'b1;
            pcr_wdata_i = d;
            step(1);
            pcr_wr_i = 1'b0;
            step(1);
            chk(16'(power_control_register_o), 16'(d & PCR_PLAIN_MASK), "plain write");
            chk(16'(stop_mode_o), 16'h0, "stop refused");
        end
        ta_write(1'b1, 8'h02);
        chk(16'(stop_mode_o), 16'h1, "stop entered");
        chk(16'(power_control_register_o), 16'h02, "stop view");
        n = 0;
        repeat (24)
        begin
            step(1);
            n += int'(ale_o !== 1'b0);
        end
        chk(16'(n), 16'h0, "strobe halted in stop");
        por();
        ta_write(1'b0, 8'h00);
        // Fetch select over access pin and lock
        for (int i = 0; i < 4; i++)
        begin
            {external_access_input_n_i, lock_i} = 2'(i);
            step(1);
            chk(16'(ext_bus_fetch_o), 16'(i == 0), "bus fetch");
            chk(16'(int_nvram_en_o), 16'(i != 0), "internal memory");
        end
        // Program store contents and their check value
        crc = CRC_INIT;
        mem_wr_i = 1'b1;
        for (int a = 0; a < (1 << AW); a++)
        begin
            mem_addr_i = AW'(a);
            mem_wdata_i = 8'($random(seed));
            crc = crc_add(crc, mem_wdata_i);
            step(1);
        end
        mem_wr_i = 1'b0;
        check_en_i = 1'b1;
        for (int f = 0; f < 2; f++)
        begin
            check_stored_i = crc ^ 16'(f);
            por();
            ta_write(1'b0, 8'h00);
            n = 0;
            while (app_run_o !== 1'b1 && check_fail_o !== 1'b1 && n < 200)
            begin
                step(1);
                n++;
            end
            step(40);
            chk(check_value_o, crc, "check value");
            chk(16'(app_run_o), 16'(f == 0), "application runs");
            chk(16'(check_fail_o), 16'(f), "check failed");
            chk(16'(loader_mode_o), 16'(f), "loader kept");
            if (f == 1)
            begin
                exp_q.push_back(2'h2);
                ext_reset_i = 1'b1;
                step(2);
                ext_reset_i = 1'b0;
                wait_run();
                step(4);
                chk(16'(loader_mode_o), 16'h1, "loader after pin reset");
                chk(16'(app_run_o), 16'h0, "no application after pin reset");
            end
        end
        chk(16'(exp_q.size()), 16'h0, "expected resets missing");
        give_verdict();
    end
endmodule
